// ---- shared/urxf_pkg.sv ----
package urxf_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [1:0] ADDR_STATUS_CTRL = 2'h0; // rx_status_control_reg
  localparam logic [1:0] ADDR_DATA = 2'h1; // rx_data_reg
  localparam logic [1:0] ADDR_IRQ = 2'h2; // irq enables and pending flag

  // control and status fields
  localparam int BIT_SERIAL_PORT_ENABLE = 0; // serial_port_enable
  localparam int BIT_CONTINUOUS_RECEIVE_ENABLE = 1; // continuous_receive_enable
  localparam int BIT_NINE = 2; // nine_bit_receive_select
  localparam int BIT_ADDRESS_FILTER_ENABLE = 3; // address_filter_enable
  localparam int BIT_SYNC = 4; // synchronous mode select
  localparam int BIT_NINTH = 5; // ninth_received_bit, read only
  localparam int BIT_STOP_BIT_FAULT = 6; // stop_bit_fault, read only
  localparam int BIT_OVF = 7; // fifo_overflow_fault, read only

  // irq register fields
  localparam int BIT_RXIE = 0; // rx_interrupt_enable
  localparam int BIT_PERIPHERAL_IRQ_ENABLE = 1; // peripheral_irq_enable
  localparam int BIT_GIE = 2; // global_irq_enable
  localparam int BIT_PEND = 3; // rx_char_pending_flag, read only

  // ----------------------------------------------------------------
  // timing and sizes
  // ----------------------------------------------------------------
  localparam logic [3:0] OVS_LAST = 4'hf; // last tick of a 16-tick bit
  localparam logic [3:0] OVS_MID = 4'h8; // decision tick near bit centre
  localparam logic [3:0] BITS_EIGHT = 4'h8;
  localparam logic [3:0] BITS_NINE = 4'h9;
  localparam logic [1:0] FIFO_DEPTH = 2'h2;
  localparam int ENTRY_W = 10; // stop fault, ninth bit, eight data bits

  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [8:0] RST_CHAR = 9'h000;
  localparam logic [3:0] RST_CNT = 4'h0;

  typedef enum logic [1:0] {
    RX_IDLE,
    RX_START,
    RX_DATA,
    RX_STOP
  } urxf_state_t;
endpackage

// ---- src/urxf_majority.sv ----
`timescale 1ns/10ps
module urxf_majority (
  input wire logic clock, // system clock
  input wire logic rst, // async reset, high
  input wire logic clear, // drop history
  input wire logic tick, // 16x baud tick
  input wire logic line, // serial line level
  output logic vote // majority of last three samples
);
  typedef struct packed {
    logic [2:0] smp;
  } urxf_maj_t;

  urxf_maj_t s_reg, s_next;

  // ----------------------------------------------------------------
  // sample history
  // ----------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    if (clear) begin
      s_next.smp = 3'h7;
    end else if (tick) begin
      s_next.smp = {s_reg.smp[1:0], line};
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_reg <= '{smp: 3'h7};
    end else begin
      s_reg <= s_next;
    end
  end

  // two of three decide the bit
  assign vote = (s_reg.smp[0] & s_reg.smp[1]) | (s_reg.smp[0] & s_reg.smp[2]) |
                (s_reg.smp[1] & s_reg.smp[2]);
endmodule

// ---- src/urxf_fifo.sv ----
`timescale 1ns/10ps
module urxf_fifo (
  input wire logic clock, // system clock
  input wire logic rst, // async reset, high
  input wire logic flush, // empty all entries
  input wire logic push, // write one entry
  input wire logic [urxf_pkg::ENTRY_W-1:0] push_data, // entry in
  input wire logic pop, // drop oldest entry
  output logic [1:0] count, // entries held
  output logic [urxf_pkg::ENTRY_W-1:0] head // oldest entry
);
  typedef struct packed {
    logic [1:0] cnt;
    logic [1:0][urxf_pkg::ENTRY_W-1:0] ent;
  } urxf_fifo_t;

  urxf_fifo_t s_reg, s_next;
  logic do_pop;

  // ----------------------------------------------------------------
  // two-entry shift queue, entry 0 oldest
  // ----------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    do_pop = pop && (s_reg.cnt != 2'h0);
    if (flush) begin
      s_next.cnt = 2'h0;
      s_next.ent = '0;
    end else begin
      if (do_pop) begin
        s_next.ent[0] = s_reg.ent[1];
        s_next.cnt = s_reg.cnt - 2'h1;
      end
      if (push && (s_next.cnt != urxf_pkg::FIFO_DEPTH)) begin
        s_next.ent[s_next.cnt[0]] = push_data;
        s_next.cnt = s_next.cnt + 2'h1;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign count = s_reg.cnt;
  assign head = s_reg.ent[0];
endmodule

// ---- src/urxf_receiver.sv ----
// The plain strobed port and the placing of the registers were decided locally.
`timescale 1ns/10ps
module urxf_receiver (
  input wire logic clock, // system clock, 125 MHz
  input wire logic rst, // async reset, high
  input wire logic rx_line, // serial receive line
  input wire logic baud_tick16, // one-cycle tick at 16x baud
  input wire logic [1:0] addr, // register address
  input wire logic [7:0] wdata, // write data
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  output logic [7:0] rdata, // read data, cycle after rd
  output logic rx_char_pending_flag, // unread character held while port and receive are enabled
  output logic rx_irq // receive interrupt request
);
  typedef struct packed {
    urxf_pkg::urxf_state_t st;
    logic [3:0] tcnt;
    logic [3:0] bitn;
    logic prev_line;
    logic [8:0] shreg;
    logic serial_port_enable;
    logic continuous_receive_enable;
    logic nine;
    logic address_filter_enable;
    logic syncsel;
    logic rxie;
    logic peripheral_irq_enable;
    logic global_irq_enable;
    logic ovf;
    logic pend;
    logic irq;
    logic [7:0] rdata;
  } urxf_rx_t;

  urxf_rx_t s_reg, s_next;
  logic active;
  logic vote;
  logic done;
  logic keep;
  logic push;
  logic pop;
  logic [1:0] fifo_cnt;
  logic [urxf_pkg::ENTRY_W-1:0] head;
  logic [urxf_pkg::ENTRY_W-1:0] push_data;
  logic [3:0] nbits;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  urxf_majority u_maj (
    .clock(clock),
    .rst(rst),
    .clear(!active),
    .tick(baud_tick16),
    .line(rx_line),
    .vote(vote)
  );

  urxf_fifo u_fifo (
    .clock(clock),
    .rst(rst),
    .flush(!s_reg.serial_port_enable),
    .push(push),
    .push_data(push_data),
    .pop(pop),
    .count(fifo_cnt),
    .head(head)
  );

  // reception enable and character assembly
  assign active = s_reg.continuous_receive_enable && !s_reg.syncsel && s_reg.serial_port_enable;
  assign nbits = s_reg.nine ? urxf_pkg::BITS_NINE : urxf_pkg::BITS_EIGHT;
  assign done = active && baud_tick16 && (s_reg.st == urxf_pkg::RX_STOP) &&
                (s_reg.tcnt == urxf_pkg::OVS_MID);
  // in nine-bit mode the filter drops characters without ninth bit
  assign keep = !(s_reg.address_filter_enable && s_reg.nine && !s_reg.shreg[8]);
  // stop level low marks the entry faulty
  assign push_data = {!vote, s_reg.nine & s_reg.shreg[8], s_reg.shreg[7:0]};
  assign pop = rd && (addr == urxf_pkg::ADDR_DATA);
  // refused while overflow stands, accepted despite earlier faults
  assign push = done && keep && !s_reg.ovf &&
                ((fifo_cnt != urxf_pkg::FIFO_DEPTH) || pop);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    // bit recovery on external tick only
    if (!active) begin
      s_next.st = urxf_pkg::RX_IDLE;
      s_next.tcnt = urxf_pkg::RST_CNT;
      s_next.prev_line = 1'b1;
    end else if (baud_tick16) begin
      s_next.prev_line = rx_line;
      s_next.tcnt = s_reg.tcnt + 4'h1;
      case (s_reg.st)
        urxf_pkg::RX_IDLE: begin
          s_next.tcnt = urxf_pkg::RST_CNT;
          if (s_reg.prev_line && !rx_line) begin
            s_next.st = urxf_pkg::RX_START;
            s_next.tcnt = 4'h1;
          end
        end
        urxf_pkg::RX_START: begin
          if (s_reg.tcnt == urxf_pkg::OVS_MID && vote) begin
            s_next.st = urxf_pkg::RX_IDLE;
          end else if (s_reg.tcnt == urxf_pkg::OVS_LAST) begin
            s_next.st = urxf_pkg::RX_DATA;
            s_next.bitn = urxf_pkg::RST_CNT;
            s_next.shreg = urxf_pkg::RST_CHAR;
          end
        end
        urxf_pkg::RX_DATA: begin
          if (s_reg.tcnt == urxf_pkg::OVS_MID) begin
            s_next.shreg[s_reg.bitn] = vote;
          end
          if (s_reg.tcnt == urxf_pkg::OVS_LAST) begin
            s_next.bitn = s_reg.bitn + 4'h1;
            if (s_reg.bitn + 4'h1 == nbits) begin
              s_next.st = urxf_pkg::RX_STOP;
            end
          end
        end
        urxf_pkg::RX_STOP: begin
          if (s_reg.tcnt == urxf_pkg::OVS_MID) begin
            s_next.st = urxf_pkg::RX_IDLE;
          end
        end
        default: begin
          s_next.st = urxf_pkg::RX_IDLE;
        end
      endcase
    end
    // overflow: set on refused third character, cleared by enables
    if (done && keep && (fifo_cnt == urxf_pkg::FIFO_DEPTH) && !pop) begin
      s_next.ovf = 1'b1;
    end
    if (!s_reg.continuous_receive_enable || !s_reg.serial_port_enable) begin
      s_next.ovf = 1'b0;
    end
    // register writes; status bits are not writable
    if (wr && addr == urxf_pkg::ADDR_STATUS_CTRL) begin
      s_next.serial_port_enable = wdata[urxf_pkg::BIT_SERIAL_PORT_ENABLE];
      s_next.continuous_receive_enable = wdata[urxf_pkg::BIT_CONTINUOUS_RECEIVE_ENABLE];
      s_next.nine = wdata[urxf_pkg::BIT_NINE];
      s_next.address_filter_enable = wdata[urxf_pkg::BIT_ADDRESS_FILTER_ENABLE];
      s_next.syncsel = wdata[urxf_pkg::BIT_SYNC];
    end
    if (wr && addr == urxf_pkg::ADDR_IRQ) begin
      s_next.rxie = wdata[urxf_pkg::BIT_RXIE];
      s_next.peripheral_irq_enable = wdata[urxf_pkg::BIT_PERIPHERAL_IRQ_ENABLE];
      s_next.global_irq_enable = wdata[urxf_pkg::BIT_GIE];
    end
    // pending follows occupancy while port and receive are enabled
    s_next.pend = (fifo_cnt != 2'h0) && s_reg.serial_port_enable && s_reg.continuous_receive_enable;
    // interrupt from pending and enables, never from a fault
    s_next.irq = s_next.pend && s_next.rxie && s_next.peripheral_irq_enable && s_next.global_irq_enable;
    // read data path, valid cycle after strobe
    s_next.rdata = urxf_pkg::RST_BYTE;
    if (rd) begin
      case (addr)
        urxf_pkg::ADDR_STATUS_CTRL: begin
          s_next.rdata[urxf_pkg::BIT_SERIAL_PORT_ENABLE] = s_reg.serial_port_enable;
          s_next.rdata[urxf_pkg::BIT_CONTINUOUS_RECEIVE_ENABLE] = s_reg.continuous_receive_enable;
          s_next.rdata[urxf_pkg::BIT_NINE] = s_reg.nine;
          s_next.rdata[urxf_pkg::BIT_ADDRESS_FILTER_ENABLE] = s_reg.address_filter_enable;
          s_next.rdata[urxf_pkg::BIT_SYNC] = s_reg.syncsel;
          s_next.rdata[urxf_pkg::BIT_NINTH] = (fifo_cnt != 2'h0) & head[8];
          s_next.rdata[urxf_pkg::BIT_STOP_BIT_FAULT] = (fifo_cnt != 2'h0) & head[9];
          s_next.rdata[urxf_pkg::BIT_OVF] = s_reg.ovf;
        end
        urxf_pkg::ADDR_DATA: begin
          s_next.rdata = (fifo_cnt != 2'h0) ? head[7:0] : urxf_pkg::RST_BYTE;
        end
        urxf_pkg::ADDR_IRQ: begin
          s_next.rdata[urxf_pkg::BIT_RXIE] = s_reg.rxie;
          s_next.rdata[urxf_pkg::BIT_PERIPHERAL_IRQ_ENABLE] = s_reg.peripheral_irq_enable;
          s_next.rdata[urxf_pkg::BIT_GIE] = s_reg.global_irq_enable;
          s_next.rdata[urxf_pkg::BIT_PEND] = s_reg.pend;
        end
        default: begin
          s_next.rdata = urxf_pkg::RST_BYTE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_reg <= '{st: urxf_pkg::RX_IDLE, tcnt: urxf_pkg::RST_CNT, bitn: urxf_pkg::RST_CNT,
                 prev_line: 1'b1, shreg: urxf_pkg::RST_CHAR, serial_port_enable: 1'b0, continuous_receive_enable: 1'b0,
                 nine: 1'b0, address_filter_enable: 1'b0, syncsel: 1'b0, rxie: 1'b0, peripheral_irq_enable: 1'b0,
                 global_irq_enable: 1'b0, ovf: 1'b0, pend: 1'b0, irq: 1'b0, rdata: urxf_pkg::RST_BYTE};
    end else begin
      s_reg <= s_next;
    end
  end

  assign rdata = s_reg.rdata;
  assign rx_char_pending_flag = s_reg.pend;
  assign rx_irq = s_reg.irq;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_char_end;
    done && keep;
  endsequence

  sequence s_full_no_read;
    (fifo_cnt == 2'h2) && !pop;
  endsequence

  property p_pend_follows;
    ((fifo_cnt != 2'h0) && s_reg.serial_port_enable && s_reg.continuous_receive_enable) |=> s_reg.pend;
  endproperty
  a_pend_follows: assert property (p_pend_follows) else $error("pending flag missing");

  property p_pend_empty;
    ((fifo_cnt == 2'h0) && wr) |=> !s_reg.pend;
  endproperty
  a_pend_empty: assert property (p_pend_empty) else $error("pending set by write");

  property p_irq_gate;
    s_reg.irq == (s_reg.pend && s_reg.rxie && s_reg.peripheral_irq_enable && s_reg.global_irq_enable);
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq not gated by enables");

  property p_push_count;
    (push && !pop && (fifo_cnt < 2'h2)) |=> (fifo_cnt == $past(fifo_cnt) + 2'h1);
  endproperty
  a_push_count: assert property (p_push_count) else $error("character not stored");

  property p_overflow_set;
    (s_char_end and s_full_no_read) ##0 (s_reg.continuous_receive_enable && s_reg.serial_port_enable && !wr) |=> s_reg.ovf;
  endproperty
  a_overflow_set: assert property (p_overflow_set) else $error("overflow not set");

  property p_overflow_block;
    s_reg.ovf |-> !push;
  endproperty
  a_overflow_block: assert property (p_overflow_block) else $error("push in overflow");

  property p_overflow_clear;
    !s_reg.continuous_receive_enable |=> !s_reg.ovf;
  endproperty
  a_overflow_clear: assert property (p_overflow_clear) else $error("overflow held");

  property p_serial_port_enable_flush;
    !s_reg.serial_port_enable |=> (fifo_cnt == 2'h0) ##1 !s_reg.pend;
  endproperty
  a_serial_port_enable_flush: assert property (p_serial_port_enable_flush) else $error("disable kept data");

  property p_read_pop;
    (pop && s_reg.serial_port_enable && (fifo_cnt != 2'h0) && !push) |=> (fifo_cnt == $past(fifo_cnt) - 2'h1) &&
      (rdata == $past(head[7:0]));
  endproperty
  a_read_pop: assert property (p_read_pop) else $error("read did not advance");

  property p_start_abort;
    (active && baud_tick16 && s_reg.st == urxf_pkg::RX_START &&
     s_reg.tcnt == urxf_pkg::OVS_MID && vote) |=> (s_reg.st == urxf_pkg::RX_IDLE);
  endproperty
  a_start_abort: assert property (p_start_abort) else $error("false start kept");

  property p_filter;
    push |-> (!(s_reg.address_filter_enable && s_reg.nine) || s_reg.shreg[8]);
  endproperty
  a_filter: assert property (p_filter) else $error("filtered character stored");
endmodule

// ---- sim/urxf_tx_model.sv ----
`timescale 1ns/10ps
// remote transmitter: drives the serial line from the shared 16x tick
module urxf_tx_model (
  input wire logic clock, // system clock
  input wire logic tick, // 16x baud tick
  output logic line // serial line, idle high
);
  // line idles high between frames
  initial begin
    line = 1'b1;
  end

  // ----------------------------------------------------------------
  // timing helpers
  // ----------------------------------------------------------------
  // count n ticks, returning just after the edge that took the last one
  task automatic wait_ticks(input int n);
    repeat (n) begin
      @(posedge clock);
      while (tick !== 1'b1) begin
        @(posedge clock);
      end
    end
  endtask

  // ----------------------------------------------------------------
  // frames
  // ----------------------------------------------------------------
  // start bit, data lsb first, stop bit at the level asked for
  task automatic send(input logic [8:0] d, input logic nine, input logic stop_lvl);
    int nb;
    nb = nine ? 9 : 8;
    line <= 1'b0;
    wait_ticks(16);
    for (int i = 0; i < nb; i++) begin
      line <= d[i];
      wait_ticks(16);
    end
    line <= stop_lvl;
    wait_ticks(16);
    line <= 1'b1;
    wait_ticks(4);
  endtask

  // short low pulse, back high well before mid start bit
  task automatic glitch();
    line <= 1'b0;
    wait_ticks(3);
    line <= 1'b1;
    wait_ticks(32);
  endtask
endmodule

// ---- sim/urxf_receiver_tb.sv ----
`timescale 1ns/10ps
`define CHK(g, e) begin \
  n_compared++; \
  if ((g) !== (e)) begin \
    fail_count++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); \
  end \
end
module urxf_receiver_tb;
  logic clock;
  logic rst;
  logic rx_line;
  logic baud_tick16;
  logic [1:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  logic rx_char_pending_flag;
  logic rx_irq;
  logic [1:0] tick_div;
  int fail_count;
  int n_compared;
  int cycles;

  urxf_receiver i_dut (
    .clock(clock),
    .rst(rst),
    .rx_line(rx_line),
    .baud_tick16(baud_tick16),
    .addr(addr),
    .wdata(wdata),
    .wr(wr),
    .rd(rd),
    .rdata(rdata),
    .rx_char_pending_flag(rx_char_pending_flag),
    .rx_irq(rx_irq)
  );

  urxf_tx_model i_tx (
    .clock(clock),
    .tick(baud_tick16),
    .line(rx_line)
  );

  // ----------------------------------------------------------------
  // clock, tick and timeout
  // ----------------------------------------------------------------
  // 125 MHz system clock
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // one-cycle tick every fourth clock
  always @(posedge clock) begin
    tick_div <= tick_div + 2'h1;
    baud_tick16 <= (tick_div == 2'h3);
  end

  // cut a hang short
  always @(posedge clock) begin
    cycles++;
    if (cycles == 60000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  // ----------------------------------------------------------------
  // register access
  // ----------------------------------------------------------------
  task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [1:0] a, output logic [7:0] d);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic chk_reg(input logic [1:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd_reg(a, d);
    `CHK(d, e)
  endtask

  task automatic tally_and_finish();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    addr = 2'h0;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    baud_tick16 = 1'b0;
    tick_div = 2'h0;
    fail_count = 0;
    n_compared = 0;
    cycles = 0;
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    // reset values and the unmapped place
    chk_reg(urxf_pkg::ADDR_STATUS_CTRL, 8'h00);
    chk_reg(urxf_pkg::ADDR_IRQ, 8'h00);
    wr_reg(2'h3, 8'hff);
    chk_reg(2'h3, 8'h00);
    // setup: port, irq enables, then receive enable last
    wr_reg(urxf_pkg::ADDR_STATUS_CTRL, 8'h01);
    wr_reg(urxf_pkg::ADDR_IRQ, 8'h07);
    wr_reg(urxf_pkg::ADDR_STATUS_CTRL, 8'h03);
    // plain character, pending, irq, read-only pending, pop
    i_tx.send(9'h0a5, 1'b0, 1'b1);
    `CHK(rx_char_pending_flag, 1'b1)
    `CHK(rx_irq, 1'b1)
    wr_reg(urxf_pkg::ADDR_IRQ, 8'h07);
    chk_reg(urxf_pkg::ADDR_IRQ, 8'h0f);
    wr_reg(urxf_pkg::ADDR_IRQ, 8'h03);
    #1;
    `CHK(rx_irq, 1'b0)
    `CHK(rx_char_pending_flag, 1'b1)
    chk_reg(urxf_pkg::ADDR_STATUS_CTRL, 8'h03);
    chk_reg(urxf_pkg::ADDR_DATA, 8'ha5);
    repeat (2) @(posedge clock);
    `CHK(rx_char_pending_flag, 1'b0)
    wr_reg(urxf_pkg::ADDR_IRQ, 8'h0f);
    chk_reg(urxf_pkg::ADDR_IRQ, 8'h07);
    // faulted then clean: status follows the oldest entry
    i_tx.send(9'h03c, 1'b0, 1'b0);
    i_tx.send(9'h0c3, 1'b0, 1'b1);
    chk_reg(urxf_pkg::ADDR_STATUS_CTRL, 8'h43);
    chk_reg(urxf_pkg::ADDR_DATA, 8'h3c);
    chk_reg(urxf_pkg::ADDR_STATUS_CTRL, 8'h03);
    chk_reg(urxf_pkg::ADDR_DATA, 8'hc3);
    // both faulted: fault stays across a read
    i_tx.send(9'h011, 1'b0, 1'b0);
    i_tx.send(9'h022, 1'b0, 1'b0);
    chk_reg(urxf_pkg::ADDR_DATA, 8'h11);
    chk_reg(urxf_pkg::ADDR_STATUS_CTRL, 8'h43);
    chk_reg(urxf_pkg::ADDR_DATA, 8'h22);
    repeat (2) @(posedge clock);
    `CHK(rx_irq, 1'b0)
    // overflow: third char lost, fourth refused, cleared by receive enable
    i_tx.send(9'h031, 1'b0, 1'b1);
    i_tx.send(9'h032, 1'b0, 1'b1);
    i_tx.send(9'h033, 1'b0, 1'b1);
    chk_reg(urxf_pkg::ADDR_STATUS_CTRL, 8'h83);
    chk_reg(urxf_pkg::ADDR_DATA, 8'h31);
    chk_reg(urxf_pkg::ADDR_DATA, 8'h32);
    chk_reg(urxf_pkg::ADDR_DATA, 8'h00);
    i_tx.send(9'h034, 1'b0, 1'b1);
    `CHK(rx_char_pending_flag, 1'b0)
    chk_reg(urxf_pkg::ADDR_STATUS_CTRL, 8'h83);
    wr_reg(urxf_pkg::ADDR_STATUS_CTRL, 8'h01);
    chk_reg(urxf_pkg::ADDR_STATUS_CTRL, 8'h01);
    // nine-bit characters, status read before data
    wr_reg(urxf_pkg::ADDR_STATUS_CTRL, 8'h07);
    i_tx.send(9'h1ab, 1'b1, 1'b1);
    i_tx.send(9'h0cd, 1'b1, 1'b1);
    chk_reg(urxf_pkg::ADDR_STATUS_CTRL, 8'h27);
    chk_reg(urxf_pkg::ADDR_DATA, 8'hab);
    chk_reg(urxf_pkg::ADDR_STATUS_CTRL, 8'h07);
    chk_reg(urxf_pkg::ADDR_DATA, 8'hcd);
    // address filter: data dropped, address kept, then filter off
    wr_reg(urxf_pkg::ADDR_STATUS_CTRL, 8'h0f);
    i_tx.send(9'h055, 1'b1, 1'b1);
    `CHK(rx_char_pending_flag, 1'b0)
    i_tx.send(9'h1aa, 1'b1, 1'b1);
    chk_reg(urxf_pkg::ADDR_STATUS_CTRL, 8'h2f);
    chk_reg(urxf_pkg::ADDR_DATA, 8'haa);
    wr_reg(urxf_pkg::ADDR_STATUS_CTRL, 8'h07);
    i_tx.send(9'h012, 1'b1, 1'b1);
    chk_reg(urxf_pkg::ADDR_DATA, 8'h12);
    // false start is dropped silently
    wr_reg(urxf_pkg::ADDR_STATUS_CTRL, 8'h03);
    i_tx.glitch();
    repeat (640) @(posedge clock);
    `CHK(rx_char_pending_flag, 1'b0)
    chk_reg(urxf_pkg::ADDR_STATUS_CTRL, 8'h03);
    // synchronous select blocks reception
    wr_reg(urxf_pkg::ADDR_STATUS_CTRL, 8'h13);
    i_tx.send(9'h066, 1'b0, 1'b1);
    `CHK(rx_char_pending_flag, 1'b0)
    // receive enable off keeps the fault, port enable off clears it
    wr_reg(urxf_pkg::ADDR_STATUS_CTRL, 8'h03);
    i_tx.send(9'h077, 1'b0, 1'b0);
    wr_reg(urxf_pkg::ADDR_STATUS_CTRL, 8'h01);
    chk_reg(urxf_pkg::ADDR_STATUS_CTRL, 8'h41);
    `CHK(rx_char_pending_flag, 1'b0)
    wr_reg(urxf_pkg::ADDR_STATUS_CTRL, 8'h00);
    chk_reg(urxf_pkg::ADDR_STATUS_CTRL, 8'h00);
    wr_reg(urxf_pkg::ADDR_STATUS_CTRL, 8'h03);
    chk_reg(urxf_pkg::ADDR_DATA, 8'h00);
    tally_and_finish();
  end
endmodule
